//--- src/sic_pkg.sv
package sic_pkg;

  // ----------------------------------------------------------------
  // Bus addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h41;
  localparam logic RW_WRITE = 1'b0;
  localparam int REG_AW = 8;

  // ----------------------------------------------------------------
  // Transfer shape
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] MAX_BYTES = 3'h4;
  localparam logic [2:0] IDX_FIRST = 3'h0;
  localparam logic [2:0] IDX_STEP = 3'h1;

  // ----------------------------------------------------------------
  // Strap capture and buffering
  // ----------------------------------------------------------------
  // Cycles after reset release before the synchronised strap is trusted
  localparam logic [1:0] STRAP_DLY = 2'h3;
  localparam logic [1:0] STRAP_STEP = 2'h1;
  localparam logic STRAP_BUS_LEVEL = 1'b0;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 18;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_REG      = 3'b011,
    ST_REG_ACK  = 3'b100,
    ST_DATA     = 3'b101,
    ST_DATA_ACK = 3'b110
  } sic_state_t;

endpackage

//--- src/sic_fifo.sv
`timescale 1ns/1ns
module sic_fifo #(
  parameter int WIDTH = sic_pkg::FIFO_W,
  parameter int DEPTH = sic_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  // Depth must be a power of two; the extra pointer bit tells full from empty
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic [AW:0] nxt_wr_ptr;
  logic [AW:0] nxt_rd_ptr;
  logic do_push;
  logic do_pop;
  logic full;
  logic empty;

  always_comb begin
    empty = (wr_ptr_ff == rd_ptr_ff);
    full = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) && (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
    in_ready = !full;
    out_valid = !empty;
    do_push = in_valid && !full;
    do_pop = out_ready && !empty;
    nxt_wr_ptr = do_push ? wr_ptr_ff + (AW+1)'(1) : wr_ptr_ff;
    nxt_rd_ptr = do_pop ? rd_ptr_ff + (AW+1)'(1) : rd_ptr_ff;
    out_data = mem[rd_ptr_ff[AW-1:0]];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  // No reset on the array: contents are only read behind a valid pointer
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

endmodule

//--- src/sic_i2c_slave.sv
`timescale 1ns/1ns
module sic_i2c_slave #(
  parameter int FIFO_DEPTH = sic_pkg::FIFO_DEPTH,
  parameter logic [6:0] DEV_ADDR = sic_pkg::DEV_ADDR
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic STRAP_BUS_N,
  input wire logic MEAS_READY,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic UART_MODE,
  output logic BUS_BUSY,
  output logic WR_VALID,
  input wire logic WR_READY,
  output logic [7:0] WR_REG,
  output logic [1:0] WR_IDX,
  output logic [7:0] WR_DATA
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic scl_m_ff, scl_s_ff, scl_q_ff;
  logic sda_m_ff, sda_s_ff, sda_q_ff;
  logic rdy_m_ff, rdy_s_ff;
  logic strap_m_ff, strap_s_ff;
  logic nxt_scl_q, nxt_sda_q;

  always_comb begin
    nxt_scl_q = scl_s_ff;
    nxt_sda_q = sda_s_ff;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_q_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      rdy_m_ff <= 1'b0;
      rdy_s_ff <= 1'b0;
      strap_m_ff <= 1'b1;
      strap_s_ff <= 1'b1;
    end else begin
      scl_m_ff <= SCL_IN;
      scl_s_ff <= scl_m_ff;
      scl_q_ff <= nxt_scl_q;
      sda_m_ff <= SDA_IN;
      sda_s_ff <= sda_m_ff;
      sda_q_ff <= nxt_sda_q;
      rdy_m_ff <= MEAS_READY;
      rdy_s_ff <= rdy_m_ff;
      strap_m_ff <= STRAP_BUS_N;
      strap_s_ff <= strap_m_ff;
    end
  end

  logic scl_rise, scl_fall, start_cond, stop_cond;

  // A data change while SCL stays high is a start or a stop
  always_comb begin
    scl_rise = scl_s_ff && !scl_q_ff;
    scl_fall = !scl_s_ff && scl_q_ff;
    start_cond = scl_s_ff && scl_q_ff && sda_q_ff && !sda_s_ff;
    stop_cond = scl_s_ff && scl_q_ff && !sda_q_ff && sda_s_ff;
  end

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Waits for the synchroniser to fill, then freezes the mode until next reset
  logic [1:0] strap_cnt_ff, nxt_strap_cnt;
  logic lock_ff, nxt_lock;
  logic uart_ff, nxt_uart;

  always_comb begin
    nxt_strap_cnt = strap_cnt_ff;
    nxt_lock = lock_ff;
    nxt_uart = uart_ff;
    if (!lock_ff) begin
      if (strap_cnt_ff == sic_pkg::STRAP_DLY) begin
        nxt_lock = 1'b1;
        nxt_uart = (strap_s_ff != sic_pkg::STRAP_BUS_LEVEL);
      end else begin
        nxt_strap_cnt = strap_cnt_ff + sic_pkg::STRAP_STEP;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strap_cnt_ff <= 2'h0;
      lock_ff <= 1'b0;
      uart_ff <= 1'b0;
    end else begin
      strap_cnt_ff <= nxt_strap_cnt;
      lock_ff <= nxt_lock;
      uart_ff <= nxt_uart;
    end
  end

  // ----------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------
  logic push;
  logic push_ready;
  logic [sic_pkg::FIFO_W-1:0] push_word;
  logic [sic_pkg::FIFO_W-1:0] pop_word;

  sic_fifo #(
    .WIDTH(sic_pkg::FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(WR_VALID),
    .out_ready(WR_READY),
    .out_data(pop_word)
  );

  always_comb begin
    WR_REG = pop_word[17:10];
    WR_IDX = pop_word[9:8];
    WR_DATA = pop_word[7:0];
  end

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  sic_pkg::sic_state_t state_ff, nxt_state;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic full8_ff, nxt_full8;
  logic ack_ff, nxt_ack;
  logic [7:0] reg_ff, nxt_reg;
  logic [2:0] idx_ff, nxt_idx;
  logic busy_ff, nxt_busy;
  logic active, byte_end, addr_hit, room;

  function automatic logic is_ack_state(input sic_pkg::sic_state_t s);
    return (s == sic_pkg::ST_ADDR_ACK) || (s == sic_pkg::ST_REG_ACK) || (s == sic_pkg::ST_DATA_ACK);
  endfunction

  always_comb begin
    active = lock_ff && !uart_ff && !rdy_s_ff;
    byte_end = scl_fall && full8_ff;
    addr_hit = (shift_ff[7:1] == DEV_ADDR) && (shift_ff[0] == sic_pkg::RW_WRITE);
    room = (idx_ff < sic_pkg::MAX_BYTES) && push_ready;
    push = active && !start_cond && !stop_cond && (state_ff == sic_pkg::ST_DATA) && byte_end && room;
    push_word = {reg_ff, idx_ff[1:0], shift_ff};
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_full8 = full8_ff;
    nxt_ack = ack_ff;
    nxt_reg = reg_ff;
    nxt_idx = idx_ff;
    if (!active) begin
      nxt_state = sic_pkg::ST_IDLE;
      nxt_ack = 1'b0;
      nxt_full8 = 1'b0;
    end else if (stop_cond) begin
      nxt_state = sic_pkg::ST_IDLE;
      nxt_ack = 1'b0;
      nxt_full8 = 1'b0;
    end else if (start_cond) begin
      // A start inside a transfer is out of sequence and drops it
      nxt_state = (state_ff == sic_pkg::ST_IDLE) ? sic_pkg::ST_ADDR : sic_pkg::ST_IDLE;
      nxt_bit_cnt = sic_pkg::BIT_FIRST;
      nxt_full8 = 1'b0;
      nxt_ack = 1'b0;
    end else begin
      unique case (state_ff)
        sic_pkg::ST_IDLE: begin
          nxt_ack = 1'b0;
        end
        sic_pkg::ST_ADDR, sic_pkg::ST_REG, sic_pkg::ST_DATA: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_s_ff};
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            nxt_full8 = (bit_cnt_ff == sic_pkg::BIT_LAST);
          end else if (byte_end) begin
            nxt_full8 = 1'b0;
            nxt_bit_cnt = sic_pkg::BIT_FIRST;
            if (state_ff == sic_pkg::ST_ADDR) begin
              nxt_ack = addr_hit;
              nxt_state = addr_hit ? sic_pkg::ST_ADDR_ACK : sic_pkg::ST_IDLE;
            end else if (state_ff == sic_pkg::ST_REG) begin
              nxt_reg = shift_ff;
              nxt_idx = sic_pkg::IDX_FIRST;
              nxt_ack = 1'b1;
              nxt_state = sic_pkg::ST_REG_ACK;
            end else begin
              // Fifth byte or a full buffer is refused with no acknowledge
              nxt_ack = room;
              nxt_idx = room ? idx_ff + sic_pkg::IDX_STEP : idx_ff;
              nxt_state = room ? sic_pkg::ST_DATA_ACK : sic_pkg::ST_IDLE;
            end
          end
        end
        sic_pkg::ST_ADDR_ACK, sic_pkg::ST_REG_ACK, sic_pkg::ST_DATA_ACK: begin
          if (scl_fall) begin
            nxt_ack = 1'b0;
            nxt_state = (state_ff == sic_pkg::ST_ADDR_ACK) ? sic_pkg::ST_REG : sic_pkg::ST_DATA;
          end
        end
        default: begin
          nxt_state = sic_pkg::ST_IDLE;
          nxt_ack = 1'b0;
        end
      endcase
    end
    nxt_busy = (nxt_state != sic_pkg::ST_IDLE);
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= sic_pkg::ST_IDLE;
      bit_cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      full8_ff <= 1'b0;
      ack_ff <= 1'b0;
      reg_ff <= 8'h00;
      idx_ff <= 3'h0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      full8_ff <= nxt_full8;
      ack_ff <= nxt_ack;
      reg_ff <= nxt_reg;
      idx_ff <= nxt_idx;
      busy_ff <= nxt_busy;
    end
  end

  // Open drain: only ever pulls low, and only for an acknowledge
  always_comb begin
    SDA_OUT = 1'b0;
    SDA_OE = ack_ff;
    UART_MODE = uart_ff;
    BUS_BUSY = busy_ff;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_good_addr;
    active && !start_cond && !stop_cond && state_ff == sic_pkg::ST_ADDR && byte_end && addr_hit;
  endsequence

  sequence s_ack_slot;
    SDA_OE && state_ff == sic_pkg::ST_ADDR_ACK;
  endsequence

  oe_in_ack_a: assert property (SDA_OE |-> is_ack_state(state_ff))
    else $error("SDA driven outside an acknowledge slot");

  mode_frozen_a: assert property ($past(lock_ff) |-> $stable(uart_ff))
    else $error("Interface mode changed after capture");

  uart_quiet_a: assert property (uart_ff |-> state_ff == sic_pkg::ST_IDLE && !SDA_OE)
    else $error("Bus slave active in UART mode");

  addr_ack_a: assert property (s_good_addr |=> s_ack_slot)
    else $error("Matching write address not acknowledged");

  addr_nack_a: assert property (
    active && !start_cond && !stop_cond && state_ff == sic_pkg::ST_ADDR && byte_end && !addr_hit
    |=> state_ff == sic_pkg::ST_IDLE && !SDA_OE)
    else $error("Foreign or read address not refused");

  ack_release_a: assert property (s_ack_slot ##0 (active && scl_fall && !stop_cond && !start_cond)
    |=> !SDA_OE && state_ff == sic_pkg::ST_REG)
    else $error("Address acknowledge not followed by register byte");

  stop_idle_a: assert property (stop_cond |=> state_ff == sic_pkg::ST_IDLE)
    else $error("Stop did not return to idle");

  start_abort_a: assert property (start_cond && state_ff != sic_pkg::ST_IDLE |=> state_ff == sic_pkg::ST_IDLE)
    else $error("Out of sequence start not abandoned");

  ready_ignore_a: assert property (rdy_s_ff |=> state_ff == sic_pkg::ST_IDLE && !SDA_OE)
    else $error("Traffic seen while measurement ready high");

  byte_step_a: assert property (push |=> idx_ff == $past(idx_ff) + sic_pkg::IDX_STEP && SDA_OE)
    else $error("Data byte index did not step");

  byte_limit_a: assert property (idx_ff <= sic_pkg::MAX_BYTES)
    else $error("More than four data bytes taken");

  bit_count_a: assert property (active && state_ff == sic_pkg::ST_ADDR && scl_rise && bit_cnt_ff == sic_pkg::BIT_LAST
    && !start_cond && !stop_cond |=> full8_ff && shift_ff[0] == $past(sda_s_ff))
    else $error("Eighth bit not completing the byte");

endmodule

//--- tb/sic_bus_master.sv
`timescale 1ns/1ns
module sic_bus_master (
  input wire logic clk,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  logic sda_rel;

  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // Released line floats high through the pull-up; a driven pin only wins with a low
  assign sda = sda_oe ? (sda_rel & sda_out) : sda_rel;

  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // ----------------------------------------------------------------
  // Bus phases, a quarter of the 160 ns link period each
  // ----------------------------------------------------------------
  task automatic q();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic start();
    q();
    sda_rel = 1'b1;
    q();
    scl = 1'b1;
    q();
    q();
    sda_rel = 1'b0;
    q();
    q();
    scl = 1'b0;
  endtask

  task automatic stop();
    q();
    sda_rel = 1'b0;
    q();
    scl = 1'b1;
    q();
    q();
    sda_rel = 1'b1;
    q();
    q();
  endtask

  // Data changes only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    q();
    sda_rel = b;
    q();
    scl = 1'b1;
    q();
    q();
    s = sda;
    scl = 1'b0;
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic clk, arst_n, strap_n, meas, wr_ready, sda_out, sda_oe, uart, busy, wr_valid, scl, sda, stall, a;
  logic [7:0] wr_reg, wr_data;
  logic [1:0] wr_idx;
  logic [31:0] seed;
  logic [31:0] rseed = 32'haadfbe4e;
  logic [17:0] exp_q[$];
  logic [7:0] bad [4] = '{8'h80, 8'h84, 8'h83, 8'hc2};
  int miscompares, n_compared;

  sic_i2c_slave dut (.REF_CLK(clk), .ARST_N(arst_n), .STRAP_BUS_N(strap_n), .MEAS_READY(meas),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .UART_MODE(uart), .BUS_BUSY(busy),
    .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_REG(wr_reg), .WR_IDX(wr_idx), .WR_DATA(wr_data));
  sic_bus_master bm (.clk(clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic cmp_w(input logic [17:0] e, input logic [17:0] g);
    n_compared++;
    if (e !== g) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_b(input logic e, input logic g);
    n_compared++;
    if (e !== g) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Random consumer; stall holds it off to fill the buffer
  always @(posedge clk) begin
    rseed <= xs(rseed);
    wr_ready <= #1 ~stall & rseed[3];
  end

  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (exp_q.size() == 0) cmp_b(1'b0, 1'b1);
      else cmp_w(exp_q.pop_front(), {wr_reg, wr_idx, wr_data});
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic do_reset(input logic s);
    arst_n = 1'b0;
    strap_n = s;
    repeat (12) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask

  // ok = number of bytes acknowledged before the first refusal
  task automatic xfer(input logic [7:0] ab, input int n, input int ok);
    logic [7:0] rg, d;
    seed = xs(seed);
    rg = seed[15:8];
    bm.start();
    for (int k = 0; k < 2 + n && k <= ok; k++) begin
      seed = xs(seed);
      d = (k == 0) ? ab : (k == 1) ? rg : seed[7:0];
      if (k >= 2 && k < ok) exp_q.push_back({rg, 2'(k - 2), d});
      bm.send(d, a);
      cmp_b(k < ok, a);
    end
    bm.stop();
    repeat (6) @(posedge clk);
    #1;
    cmp_b(1'b0, busy);
  endtask

  task automatic drain();
    for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge clk);
    #1;
    cmp_b(1'b1, exp_q.size() == 0);
  endtask

  initial begin
    seed = 32'haadfbe4e;
    {arst_n, meas, stall, a, miscompares, n_compared} = '0;
    strap_n = 1'b0;
    do_reset(1'b0);
    strap_n = 1'b1;
    for (int n = 0; n <= 4; n++) xfer(8'h82, n, n + 2);
    cmp_b(1'b0, uart);
    $display("test writes done");
    foreach (bad[i]) xfer(bad[i], 1, 0);
    xfer(8'h82, 5, 6);
    $display("test refusals done");
    bm.start();
    bm.send(8'h82, a);
    bm.send(8'h10, a);
    cmp_b(1'b1, a);
    cmp_b(1'b1, busy);
    bm.start();
    bm.send(8'h82, a);
    cmp_b(1'b0, a);
    bm.stop();
    meas = 1'b1;
    xfer(8'h82, 1, 0);
    meas = 1'b0;
    $display("test abort and gating done");
    drain();
    stall = 1'b1;
    xfer(8'h82, 4, 6);
    xfer(8'h82, 4, 6);
    xfer(8'h82, 4, 2);
    cmp_b(1'b1, wr_valid);
    stall = 1'b0;
    drain();
    $display("test buffer full done");
    do_reset(1'b1);
    cmp_b(1'b1, uart);
    strap_n = 1'b0;
    xfer(8'h82, 1, 0);
    cmp_b(1'b1, uart);
    $display("test strap done");
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
